// File: src/dma_global_ctl.sv
`timescale 1ns/1ps
module dma_global_ctl
  import dma_ctl_pkg::*;
#(
  parameter int NCH   = 32,
  parameter int SW_CH = 30
) (
  // apb slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // peripheral requests and completions
  input  wire logic [NCH-1:0]   dma_req,
  output logic      [NCH-1:0]   periph_done,
  // system memory master
  output logic                  mem_req,
  output logic                  mem_we,
  output logic      [31:0]      mem_addr,
  output logic      [31:0]      mem_wdata,
  input  wire logic [31:0]      mem_rdata,
  input  wire logic             mem_ack,
  input  wire logic             mem_err,
  // interrupts
  output logic                  soft_channel_done_irq,
  output logic                  transfer_error_irq,
  output logic                  dma_irq
);
  import dma_ctl_pkg::*;

  localparam int CHW = $clog2(NCH);

  initial begin
    if (NCH < 2 || NCH > 32 || (1 << CHW) != NCH || SW_CH >= NCH) begin
      $error("dma_global_ctl: unsupported NCH or SW_CH");
    end
  end

  eng_state_e state_q;
  logic              en_q;
  logic [31:0]       base_q;
  logic [NCH-1:0]    chena_q;
  logic [NCH-1:0]    pend_q;
  logic [NCH-1:0]    req_s1_q;
  logic [NCH-1:0]    req_s2_q;
  logic [NCH-1:0]    chis_q;
  logic [EV_W-1:0]   ev_q;
  logic [EV_W-1:0]   mask_q;
  logic              err_q;
  logic [CHW-1:0]    cur_ch_q;
  logic [31:0]       src_q;
  logic [31:0]       dst_q;
  logic [31:0]       ctl_q;
  logic [31:0]       data_q;
  logic [CTL_CNT_W-1:0] left_q;
  logic [31:0]       prdata_q;
  logic              slverr_q;

  logic              wr;
  logic              setup;
  logic              hit;
  logic [NCH-1:0]    done_vec;
  logic              err_evt;
  logic              pick_vld;
  logic [CHW-1:0]    pick_ch;
  logic [31:0]       alt_base;
  logic [31:0]       cs_addr;
  logic [NCH-1:0]    chis_clr;
  logic [EV_W-1:0]   ev_clr;
  logic [EV_W-1:0]   ev_set;
  logic              item_last;

  assign setup    = psel && !penable;
  assign wr       = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_q;
  assign pslverr  = psel && penable && slverr_q;
  assign alt_base = base_q + 32'(NCH) * CS_STRIDE;
  assign cs_addr  = base_q + 32'(cur_ch_q) * CS_STRIDE;
  assign item_last = (left_q == '0);

  always_comb begin
    case (paddr)
      OFF_STATUS, OFF_CFG, OFF_CTLBASE, OFF_ALTBASE, OFF_CHENA,
      OFF_CHENA_ST, OFF_CHENA_CL, OFF_SWREQ, OFF_ERR, OFF_CHIS,
      OFF_INTSTAT, OFF_INTMASK: hit = 1'b1;
      default:                  hit = 1'b0;
    endcase
  end

  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= !hit;
      case (paddr)
        OFF_STATUS:  prdata_q <= {25'h0, state_q};
        OFF_CFG:     prdata_q <= {31'h0, en_q};
        OFF_CTLBASE: prdata_q <= base_q;
        OFF_ALTBASE: prdata_q <= alt_base;
        OFF_CHENA:   prdata_q <= 32'(chena_q);
        OFF_ERR:     prdata_q <= {31'h0, err_q};
        OFF_CHIS:    prdata_q <= 32'(chis_q);
        OFF_INTSTAT: prdata_q <= 32'(ev_q);
        OFF_INTMASK: prdata_q <= 32'(mask_q);
        default:     prdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= 1'b0;
      base_q <= RST_CTLBASE;
      mask_q <= RST_MASK;
    end else if (wr) begin
      if (paddr == OFF_CFG) en_q <= pwdata[CFG_EN_BIT];
      if (paddr == OFF_CTLBASE) begin
        base_q <= {pwdata[31:TBL_ALIGN_BITS], {TBL_ALIGN_BITS{1'b0}}};
      end
      if (paddr == OFF_INTMASK) mask_q <= pwdata[EV_W-1:0];
    end
  end

  // peripheral request lines come from other logic blocks' pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1_q <= '0;
      req_s2_q <= '0;
    end else begin
      req_s1_q <= dma_req;
      req_s2_q <= req_s1_q;
    end
  end

  // hardware disable on completion wins over a software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chena_q <= '0;
    end else begin
      chena_q <= (chena_q
                  | ((wr && paddr == OFF_CHENA_ST) ? pwdata[NCH-1:0] : '0))
                 & ~((wr && paddr == OFF_CHENA_CL) ? pwdata[NCH-1:0] : '0)
                 & ~done_vec;
    end
  end

  // one request latches the channel until serviced or its enable is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= ((pend_q & ~done_vec)
                 | req_s2_q
                 | ((wr && paddr == OFF_SWREQ) ? pwdata[NCH-1:0] : '0))
                & chena_q;
    end
  end

  always_comb begin
    pick_vld = 1'b0;
    pick_ch  = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_q[i] && chena_q[i]) begin
        pick_vld = 1'b1;
        pick_ch  = CHW'(i);
      end
    end
  end

  assign err_evt = mem_req && mem_ack && mem_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      cur_ch_q <= '0;
      src_q    <= 32'h0;
      dst_q    <= 32'h0;
      ctl_q    <= 32'h0;
      data_q   <= 32'h0;
      left_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (en_q && pick_vld) begin
            cur_ch_q <= pick_ch;
            state_q  <= ST_RD_CTL;
          end
        end
        ST_RD_CTL: begin
          if (mem_ack) begin
            ctl_q  <= mem_rdata;
            left_q <= mem_rdata[CTL_CNT_LSB +: CTL_CNT_W];
            if (mem_err ||
                mem_rdata[CTL_MODE_LSB +: CTL_MODE_W] == MODE_STOPPED) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RD_SRC;
            end
          end
        end
        ST_RD_SRC: begin
          if (mem_ack) begin
            src_q   <= mem_rdata;
            state_q <= mem_err ? ST_IDLE : ST_RD_DST;
          end
        end
        ST_RD_DST: begin
          if (mem_ack) begin
            dst_q   <= mem_rdata;
            state_q <= mem_err ? ST_IDLE : ST_RD_ITM;
          end
        end
        ST_RD_ITM: begin
          if (mem_ack) begin
            data_q  <= mem_rdata;
            state_q <= mem_err ? ST_IDLE : ST_WR_ITM;
          end
        end
        ST_WR_ITM: begin
          if (mem_ack) begin
            src_q  <= src_q + ITEM_BYTES;
            dst_q  <= dst_q + ITEM_BYTES;
            left_q <= left_q - 1'b1;
            if (mem_err) begin
              state_q <= ST_IDLE;
            end else if (item_last) begin
              state_q <= ST_WR_STP;
            end else if (!en_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RD_ITM;
            end
          end
        end
        ST_WR_STP: begin
          if (mem_ack) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = 32'h0;
    mem_wdata = 32'h0;
    case (state_q)
      ST_RD_CTL: begin
        mem_req  = 1'b1;
        mem_addr = cs_addr + CS_CTL_OFF;
      end
      ST_RD_SRC: begin
        mem_req  = 1'b1;
        mem_addr = cs_addr + CS_SRC_OFF;
      end
      ST_RD_DST: begin
        mem_req  = 1'b1;
        mem_addr = cs_addr + CS_DST_OFF;
      end
      ST_RD_ITM: begin
        mem_req  = 1'b1;
        mem_addr = src_q;
      end
      ST_WR_ITM: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = dst_q;
        mem_wdata = data_q;
      end
      ST_WR_STP: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = cs_addr + CS_CTL_OFF;
        mem_wdata = {ctl_q[31:CTL_CNT_LSB + CTL_CNT_W],
                     {CTL_CNT_W{1'b0}}, ctl_q[CTL_CNT_LSB-1:CTL_MODE_W],
                     MODE_STOPPED};
      end
      default: begin
        mem_req = 1'b0;
      end
    endcase
  end

  always_comb begin
    done_vec = '0;
    if (state_q == ST_WR_STP && mem_ack && !mem_err) begin
      done_vec[cur_ch_q] = 1'b1;
    end
  end

  // set beats clear on the error flag as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= (err_q
                && !(wr && paddr == OFF_ERR && pwdata[ERR_BIT]))
               || err_evt;
    end
  end

  assign chis_clr = (wr && paddr == OFF_CHIS) ? pwdata[NCH-1:0] : '0;
  assign ev_clr   = (wr && paddr == OFF_INTSTAT) ? pwdata[EV_W-1:0] : '0;
  assign ev_set   = {err_evt, done_vec[SW_CH]};

  sticky_w1c #(
    .W      (NCH)
  ) u_chis (
    .pclk   (pclk),
    .presetn(presetn),
    .set    (done_vec),
    .clr    (chis_clr),
    .flag_q (chis_q)
  );

  sticky_w1c #(
    .W      (EV_W)
  ) u_ev (
    .pclk   (pclk),
    .presetn(presetn),
    .set    (ev_set),
    .clr    (ev_clr),
    .flag_q (ev_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_done <= '0;
    end else begin
      periph_done <= done_vec & ~(NCH'(1) << SW_CH);
    end
  end

  assign soft_channel_done_irq = chis_q[SW_CH];
  assign transfer_error_irq    = err_q;
  assign dma_irq               = |(ev_q & mask_q);

  AST_DISABLED_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_q && state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("engine left idle while disabled");

  AST_ERR_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
    err_evt |=> transfer_error_irq && ev_q[EV_ERR_BIT])
    else $error("error not flagged");

  AST_ERR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_ERR && pwdata[ERR_BIT] && !err_evt)
    |=> !transfer_error_irq)
    else $error("error clear ignored");

  AST_CHIS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_CHIS && done_vec == '0)
    |=> (chis_q & $past(pwdata[NCH-1:0])) == '0)
    else $error("channel status not cleared");

  AST_CHIS_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_CHIS)
    |=> (($past(chis_q) & ~$past(pwdata[NCH-1:0])) & ~chis_q) == '0)
    else $error("unmasked channel status lost");

  AST_SW_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    done_vec[SW_CH] |=> soft_channel_done_irq && !periph_done[SW_CH])
    else $error("software channel done not signalled");

  AST_PERIPH_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    (done_vec != '0 && !done_vec[SW_CH])
    |=> periph_done == $past(done_vec) && !ev_q[EV_SWDONE_BIT] ||
        $past(ev_q[EV_SWDONE_BIT]))
    else $error("peripheral done misrouted");

  AST_STOP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_WR_STP |-> mem_we &&
    mem_wdata[CTL_MODE_LSB +: CTL_MODE_W] == MODE_STOPPED)
    else $error("stopped mode not written back");

  AST_AUTO_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
    done_vec != '0 |=> (chena_q & $past(done_vec)) == '0)
    else $error("channel still enabled after completion");

  AST_START: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_IDLE && en_q && pick_vld) |=> state_q == ST_RD_CTL)
    else $error("pending channel not started");

  AST_ALT_HALF: assert property (@(posedge pclk) disable iff (!presetn)
    alt_base[TBL_ALIGN_BITS-1:0] == 10'(NCH * 16))
    else $error("alternate base not in upper half");

  COV_SW_DONE: cover property (@(posedge pclk) disable iff (!presetn)
    done_vec[SW_CH]);
  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn)
    err_evt ##[1:20] !err_q);
  COV_CHIS_CLR: cover property (@(posedge pclk) disable iff (!presetn)
    chis_q != '0 ##1 wr && paddr == OFF_CHIS ##1 chis_q == '0);
  COV_PERIPH: cover property (@(posedge pclk) disable iff (!presetn)
    periph_done != '0);

endmodule : dma_global_ctl

// File: pkg/dma_ctl_pkg.sv
package dma_ctl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CFG      = 8'h04;
  localparam logic [7:0] OFF_CTLBASE  = 8'h08;
  localparam logic [7:0] OFF_ALTBASE  = 8'h0c;
  localparam logic [7:0] OFF_CHENA    = 8'h10;
  localparam logic [7:0] OFF_CHENA_ST = 8'h14;
  localparam logic [7:0] OFF_CHENA_CL = 8'h18;
  localparam logic [7:0] OFF_SWREQ    = 8'h1c;
  localparam logic [7:0] OFF_ERR      = 8'h20;
  localparam logic [7:0] OFF_CHIS     = 8'h24;
  localparam logic [7:0] OFF_INTSTAT  = 8'h28;
  localparam logic [7:0] OFF_INTMASK  = 8'h2c;

  // field positions
  localparam int CFG_EN_BIT      = 0;
  localparam int ERR_BIT         = 0;
  localparam int EV_SWDONE_BIT   = 0;
  localparam int EV_ERR_BIT      = 1;
  localparam int EV_W            = 2;
  localparam int TBL_ALIGN_BITS  = 10;
  localparam int CTL_MODE_LSB    = 0;
  localparam int CTL_MODE_W      = 3;
  localparam int CTL_CNT_LSB     = 4;
  localparam int CTL_CNT_W       = 10;

  // control structure layout inside the table
  localparam logic [31:0] CS_STRIDE  = 32'h10;
  localparam logic [31:0] CS_SRC_OFF = 32'h0;
  localparam logic [31:0] CS_DST_OFF = 32'h4;
  localparam logic [31:0] CS_CTL_OFF = 32'h8;
  localparam logic [31:0] ITEM_BYTES = 32'h4;

  // channel modes
  localparam logic [2:0] MODE_STOPPED  = 3'h0;
  localparam logic [2:0] MODE_BASIC    = 3'h1;
  localparam logic [2:0] MODE_AUTO_RUN = 3'h2;

  // reset values
  localparam logic [31:0] RST_CTLBASE = 32'h0;
  localparam logic [1:0]  RST_MASK    = 2'h0;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_RD_CTL = 7'b0000010,
    ST_RD_SRC = 7'b0000100,
    ST_RD_DST = 7'b0001000,
    ST_RD_ITM = 7'b0010000,
    ST_WR_ITM = 7'b0100000,
    ST_WR_STP = 7'b1000000
  } eng_state_e;

endpackage : dma_ctl_pkg

// File: src/sticky_w1c.sv
`timescale 1ns/1ps
// sticky flags: hardware set beats software clear
module sticky_w1c #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic      [W-1:0] flag_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr) | set;
    end
  end

endmodule : sticky_w1c

// File: verification/mem_model.sv
`timescale 1ns/1ps
// system memory seen by the engine; answers at once or after a random wait
module mem_model (
  // clock
  input  wire logic        pclk,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  output logic             mem_err,
  // pacing and fault control
  input  wire logic        fail_next,
  input  wire logic        slow
);
  logic [31:0] mem [0:1023];
  int          wait_n;

  initial begin
    mem_rdata = 32'h0;
    mem_ack   = 1'b0;
    mem_err   = 1'b0;
    wait_n    = 0;
  end

  always @(posedge pclk) begin
    mem_ack   <= 1'b0;
    mem_err   <= 1'b0;
    // released data toggles so a stale word is never mistaken for a read
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else begin
        mem_ack <= 1'b1;
        mem_err <= fail_next;
        if (mem_we) begin
          mem[mem_addr[11:2]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[11:2]];
        end
        wait_n <= slow ? $urandom_range(3, 1) : 0;
      end
    end
  end
endmodule : mem_model

// File: verification/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
  import dma_ctl_pkg::*;
  localparam int          SW = 30;
  localparam int          PC = 3;
  localparam logic [31:0] TB = 32'h400;
  typedef struct {string nm; logic [31:0] v; logic [31:0] g; logic pin;} note_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, s;
  logic        pready, pslverr, mem_req, mem_we, mem_ack, mem_err;
  logic [31:0] dma_req = 32'h0, periph_done, pd_seen = 32'h0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic        soft_channel_done_irq, transfer_error_irq, dma_irq;
  logic        fail_next = 1'b0, slow = 1'b0, count_on = 1'b0;
  int          num_errors = 0, num_checks = 0, busy_n = 0, n_items;
  note_s       exp_q[$];

  always #10 pclk = ~pclk;

  dma_global_ctl #(.NCH(32), .SW_CH(SW)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_req(dma_req),
    .periph_done(periph_done), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_err(mem_err),
    .soft_channel_done_irq(soft_channel_done_irq),
    .transfer_error_irq(transfer_error_irq), .dma_irq(dma_irq));

  mem_model mem_i (
    .pclk(pclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_err(mem_err), .fail_next(fail_next), .slow(slow));

  // pin notes first, then the read that completes at this edge
  always @(posedge pclk) begin
    pd_seen <= pd_seen | periph_done;
    if (count_on && mem_req) busy_n++;
    while (exp_q.size() > 0 && exp_q[0].pin) begin
      `CHK(exp_q[0].nm, exp_q[0].v, exp_q[0].g)
      void'(exp_q.pop_front());
    end
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      `CHK(exp_q[0].nm, exp_q[0].v, prdata)
      void'(exp_q.pop_front());
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // idle edge at the end keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    s = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    exp_q.push_back('{n, e, 32'h0, 1'b0});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic pin(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    exp_q.push_back('{n, e, g, 1'b1});
  endtask : pin

  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask : tdone

  task automatic setup_ch(input int ch, input logic [2:0] md, input int n);
    int b;
    b = (TB >> 2) + ch * 4;
    mem_i.mem[b]     = 32'h800;
    mem_i.mem[b + 1] = 32'hc00;
    mem_i.mem[b + 2] = {18'h0, 10'(n - 1), 1'b0, md};
    for (int i = 0; i < n; i++) begin
      mem_i.mem[10'h200 + i] = $urandom;
      mem_i.mem[10'h300 + i] = ~mem_i.mem[10'h200 + i];
    end
  endtask : setup_ch

  task automatic chk_copy(input int ch, input int n);
    for (int i = 0; i < n; i++)
      pin("item", mem_i.mem[10'h200 + i], mem_i.mem[10'h300 + i]);
    pin("ctl", 32'h0, mem_i.mem[(TB >> 2) + ch * 4 + 2] & 32'h3fff);
  endtask : chk_copy

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h4a73));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CFG, 32'h0, "cfg");
    rd(OFF_CTLBASE, RST_CTLBASE, "base");
    rd(OFF_CHENA, 32'h0, "chena");
    rd(OFF_CHIS, 32'h0, "chis");
    rd(OFF_INTMASK, {30'h0, RST_MASK}, "mask");
    rd(8'h30, 32'h0, "unmapped");
    pin("slverr", 32'h1, s);
    tdone("reset");
    wr(OFF_CFG, 32'h1);
    wr(OFF_CTLBASE, TB);
    rd(OFF_CTLBASE, TB, "base");
    rd(OFF_ALTBASE, TB + 32 * CS_STRIDE, "alt base");
    tdone("setup");
    n_items = $urandom_range(8, 1);
    slow    <= 1'b1;
    setup_ch(SW, MODE_AUTO_RUN, n_items);
    wr(OFF_CHENA_ST, 32'h1 << SW);
    wr(OFF_SWREQ, 32'h1 << SW);
    for (int i = 0; i < 800 && soft_channel_done_irq !== 1'b1; i++)
      @(posedge pclk);
    pin("done irq", 32'h1, {31'h0, soft_channel_done_irq});
    chk_copy(SW, n_items);
    rd(OFF_CHENA, 32'h0, "chena");
    pin("pdone sw", 32'h0, {31'h0, pd_seen[SW]});
    tdone("software channel");
    wr(OFF_INTSTAT, 32'h3);
    slow <= 1'b0;
    setup_ch(PC, MODE_BASIC, 2);
    wr(OFF_CHENA_ST, 32'h1 << PC);
    dma_req <= 32'h1 << PC;
    for (int i = 0; i < 800 && pd_seen[PC] !== 1'b1; i++) @(posedge pclk);
    dma_req <= 32'h0;
    pin("pdone", 32'h1, {31'h0, pd_seen[PC]});
    rd(OFF_INTSTAT, 32'h0, "event");
    chk_copy(PC, 2);
    rd(OFF_CHIS, (32'h1 << SW) | (32'h1 << PC), "chis");
    wr(OFF_CHIS, 32'h0);
    rd(OFF_CHIS, (32'h1 << SW) | (32'h1 << PC), "chis");
    wr(OFF_CHIS, 32'h1 << PC);
    rd(OFF_CHIS, 32'h1 << SW, "chis");
    wr(OFF_CHIS, 32'h1 << SW);
    rd(OFF_CHIS, 32'h0, "chis");
    pin("done irq", 32'h0, {31'h0, soft_channel_done_irq});
    tdone("peripheral channel");
    fail_next <= 1'b1;
    wr(OFF_CHENA_ST, 32'h1 << SW);
    wr(OFF_SWREQ, 32'h1 << SW);
    for (int i = 0; i < 800 && transfer_error_irq !== 1'b1; i++)
      @(posedge pclk);
    pin("err irq", 32'h1, {31'h0, transfer_error_irq});
    rd(OFF_ERR, 32'h1, "err");
    pin("irq masked", 32'h0, {31'h0, dma_irq});
    wr(OFF_INTMASK, 32'h2);
    pin("irq unmasked", 32'h1, {31'h0, dma_irq});
    // failing retries keep the engine busy until the controller is off
    wr(OFF_CFG, 32'h0);
    repeat (10) @(posedge pclk);
    count_on <= 1'b1;
    repeat (40) @(posedge pclk);
    count_on <= 1'b0;
    @(posedge pclk);
    pin("busy off", 32'h0, busy_n);
    wr(OFF_ERR, 32'h1);
    rd(OFF_ERR, 32'h0, "err");
    pin("err irq", 32'h0, {31'h0, transfer_error_irq});
    wr(OFF_INTSTAT, 32'h3);
    pin("irq cleared", 32'h0, {31'h0, dma_irq});
    wr(OFF_INTMASK, 32'h0);
    tdone("error and disable");
    repeat (3) @(posedge pclk);
    end_of_test();
  end
endmodule : tb
